/* rtl/wut_top.sv */
// wake-up timer top: registers, source select, counter, wake and irq
//
// Function
// - sleep entry wipes configuration byte images
// - 16-bit reload, zero count raises wake event
// - one decrement per tick, eight divider ratios
// - upper reload byte staged until lower write
// - coarse trim code shifts rc frequency
// - bits six, five enable rc, crystal oscillators
// - bit four selects rc or crystal source
// - bit three keeps retention ram powered
// - wake on timeout only when armed
// - lower reload byte commits full value
// - latched flag until clear, plus live event
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module wut_top (
    input wire logic mclk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [wut_pkg::ADDR_W-1:0] addr_i,
    input wire logic [wut_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [wut_pkg::DATA_W-1:0] rd_data_o,
    // oscillator pins and controls
    input wire logic rc_osc_clk_i,
    input wire logic xtal_osc_clk_i,
    output logic rc_osc_enable_o,
    output logic crystal_osc_enable_o,
    output logic [3:0] rc_osc_coarse_trim_o,
    // power manager
    input wire logic sleep_state_i,
    output logic retention_ram_power_keep_o,
    output logic wake_o,
    output logic irq_o
);
    import wut_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0] cfg_upper_img;   // written upper config byte image
    logic [7:0] rld_upper_img;   // written upper reload byte image
    logic [7:0] cfg_upper;       // applied trim and divider
    logic [7:0] cfg_lower;       // applied enables, select, arm
    logic [15:0] reload_value;   // committed reload value
    logic [15:0] load_value;     // value the counter loads or reloads
    logic commit;                // lower reload byte written
    logic apply_cfg;             // lower config byte written
    logic sleep_prev;            // sleep level last cycle
    logic sleep_entry;           // first cycle of sleep
    logic [1:0] rc_sync;         // rc pin synchroniser
    logic [1:0] xt_sync;         // crystal pin synchroniser
    logic rc_prev;               // rc level after synchroniser
    logic xt_prev;               // crystal level after synchroniser
    logic src_pulse;             // one pulse per selected source period
    logic [15:0] count;          // present count
    logic timeout;               // one-cycle timeout event
    logic timeout_flag;          // latched timeout flag
    logic flag_clr;              // software flag clear request
    logic [7:0] irq_stat;        // sticky event bits
    logic [7:0] irq_mask;        // event enables
    logic stat_rd;               // read of the sticky event register
    logic [7:0] next_rd_data;    // read mux output

    wut_tick_if tick_bus ();

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign apply_cfg = wr_i && addr_i == OFF_CFG_LOWER;
    assign commit = wr_i && addr_i == OFF_RLD_LOWER;
    assign flag_clr = wr_i && addr_i == OFF_FLAG_CLR
                      && wr_data_i[BIT_FLAG_CLR];
    assign stat_rd = rd_i && addr_i == OFF_IRQ_STAT;
    // staged upper byte and bus lower byte only while committing, else the held reload value
    assign load_value = commit ? {rld_upper_img, wr_data_i}
                               : reload_value;
    assign sleep_entry = sleep_state_i && !sleep_prev;

    // sleep edge tracking
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sleep_prev <= 1'b0;
        end else begin
            sleep_prev <= sleep_state_i;
        end
    end

    // ----------------------------------------------------------------
    // byte images: the configuration ram copy, lost in sleep
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_upper_img <= RST_CFG;
            rld_upper_img <= RST_RLD;
        end else if (sleep_entry) begin
            // contents do not survive sleep
            cfg_upper_img <= RST_CFG;
            rld_upper_img <= RST_RLD;
        end else if (wr_i) begin
            if (addr_i == OFF_CFG_UPPER) begin
                cfg_upper_img <= wr_data_i;
            end else if (addr_i == OFF_RLD_UPPER) begin
                // held back until the lower byte arrives
                rld_upper_img <= wr_data_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // applied configuration, kept by the always-on timer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_upper <= RST_CFG;
            cfg_lower <= RST_CFG;
        end else if (apply_cfg) begin
            // upper byte takes effect with the lower write
            cfg_upper <= cfg_upper_img;
            cfg_lower <= wr_data_i;
        end
    end

    // ----------------------------------------------------------------
    // reload value commit
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reload_value <= {RST_RLD, RST_RLD};
        end else if (commit) begin
            // both halves land together
            reload_value <= {rld_upper_img, wr_data_i};
        end
    end

    // ----------------------------------------------------------------
    // oscillator pin synchronisers and edge pulses
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rc_sync <= 2'b00;
            xt_sync <= 2'b00;
            rc_prev <= 1'b0;
            xt_prev <= 1'b0;
        end else begin
            rc_sync <= {rc_sync[0], rc_osc_clk_i};
            xt_sync <= {xt_sync[0], xtal_osc_clk_i};
            rc_prev <= rc_sync[1];
            xt_prev <= xt_sync[1];
        end
    end

    // pick the source, counting only while that oscillator runs
    always_comb begin
        if (cfg_lower[BIT_CLKSEL]) begin
            src_pulse = cfg_lower[BIT_RC_EN]
                        && rc_sync[1] && !rc_prev;
        end else begin
            src_pulse = cfg_lower[BIT_XTAL_EN]
                        && xt_sync[1] && !xt_prev;
        end
    end

    // ----------------------------------------------------------------
    // prescaler and countdown
    // ----------------------------------------------------------------
    wut_prescaler u_prescaler (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .src_pulse_i(src_pulse),
        .div_sel_i(cfg_upper[DIV_MSB:0]),
        .restart_i(apply_cfg),
        .tk(tick_bus.prescaler)
    );

    wut_countdown u_countdown (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .tk(tick_bus.counter),
        .load_i(commit),
        .reload_i(load_value),
        .count_o(count),
        .timeout_o(timeout)
    );

    // ----------------------------------------------------------------
    // latched timeout flag
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timeout_flag <= 1'b0;
        end else if (timeout) begin
            // a new event beats a clear in the same cycle
            timeout_flag <= 1'b1;
        end else if (flag_clr) begin
            timeout_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, mask and output
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat <= RST_MASK;
        end else begin
            // read clears, set wins
            if (stat_rd) begin
                irq_stat <= RST_MASK;
            end
            if (timeout) begin
                irq_stat[BIT_IRQ_TMO] <= 1'b1;
            end
        end
    end

    // mask written by software
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_mask <= RST_MASK;
        end else if (wr_i && addr_i == OFF_IRQ_MASK) begin
            irq_mask <= wr_data_i;
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        next_rd_data = 8'h00;
        if (!rd_i) begin
            next_rd_data = 8'h00;
        end else if (addr_i == OFF_STATUS) begin
            next_rd_data[BIT_ST_FLAG] = timeout_flag;
            next_rd_data[BIT_ST_EVENT] = count == RST_COUNT;
        end else if (addr_i == OFF_IRQ_STAT) begin
            next_rd_data = irq_stat;
        end else if (addr_i == OFF_IRQ_MASK) begin
            next_rd_data = irq_mask;
        end else begin
            // write-only and unmapped addresses read zero
            next_rd_data = 8'h00;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end

    // ----------------------------------------------------------------
    // oscillator and power outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rc_osc_enable_o <= 1'b0;
            crystal_osc_enable_o <= 1'b0;
            rc_osc_coarse_trim_o <= RST_CFG[TRIM_MSB:TRIM_LSB];
            retention_ram_power_keep_o <= 1'b0;
        end else begin
            rc_osc_enable_o <= cfg_lower[BIT_RC_EN];
            crystal_osc_enable_o <= cfg_lower[BIT_XTAL_EN];
            rc_osc_coarse_trim_o <= cfg_upper[TRIM_MSB:TRIM_LSB];
            retention_ram_power_keep_o <= cfg_lower[BIT_RETAIN];
        end
    end

    // ----------------------------------------------------------------
    // wake request
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wake_o <= 1'b0;
        end else begin
            // only an armed timer wakes a sleeping device
            wake_o <= timeout && cfg_lower[BIT_ARM] && sleep_state_i;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_SLEEP_WIPE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        sleep_state_i && !sleep_prev
        |=> cfg_upper_img == 8'h00 && rld_upper_img == 8'h00)
        else $error("byte images survived sleep entry");

    AST_UPPER_STAGED: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr_i && addr_i == OFF_RLD_UPPER
        |=> reload_value == $past(reload_value))
        else $error("upper reload byte applied before lower write");

    AST_COMMIT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr_i && addr_i == OFF_RLD_LOWER
        |=> reload_value == {$past(rld_upper_img), $past(wr_data_i)}
            && count == reload_value)
        else $error("lower reload write did not commit the value");

    AST_WAKE_CAUSE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wake_o |-> $past(timeout) && $past(cfg_lower[BIT_ARM]))
        else $error("wake without an armed timeout");

    AST_NO_WAKE_UNARMED: assert property (@(posedge mclk_i)
        disable iff (!nrst_i)
        timeout && !cfg_lower[BIT_ARM] |=> !wake_o)
        else $error("wake raised while disarmed");

    AST_WAKE_ON_ZERO: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        timeout && cfg_lower[BIT_ARM] && sleep_state_i
        |=> wake_o && count == 16'h0000)
        else $error("armed timeout did not wake");

    AST_FLAG_HOLD: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        timeout_flag && !flag_clr |=> timeout_flag)
        else $error("timeout flag dropped without clear");

    AST_FLAG_SET: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        timeout |=> timeout_flag ##1 irq_stat[BIT_IRQ_TMO] || $past(stat_rd))
        else $error("timeout not latched");

    AST_RETAIN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        apply_cfg |=> ##1 retention_ram_power_keep_o
                          == $past(wr_data_i[BIT_RETAIN], 2))
        else $error("retention power does not follow its bit");

    AST_OSC_EN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        apply_cfg |=> ##1 rc_osc_enable_o == $past(wr_data_i[BIT_RC_EN], 2)
            && crystal_osc_enable_o == $past(wr_data_i[BIT_XTAL_EN], 2))
        else $error("oscillator enables do not follow their bits");

    AST_SRC_SEL: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        src_pulse |-> (cfg_lower[BIT_CLKSEL] ? cfg_lower[BIT_RC_EN]
                                             : cfg_lower[BIT_XTAL_EN]))
        else $error("count source taken from a disabled oscillator");

endmodule // wut_top
`default_nettype wire

/* rtl/wut_pkg.sv */
// wake-up timer package: register map, field positions, reset values, tables
package wut_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 10; // register address width
    localparam int DATA_W = 8;  // register data width

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [9:0] OFF_CFG_UPPER = 10'h030c; // trim and divider
    localparam logic [9:0] OFF_CFG_LOWER = 10'h030d; // enables and arm
    localparam logic [9:0] OFF_RLD_UPPER = 10'h030e; // reload [15:8]
    localparam logic [9:0] OFF_RLD_LOWER = 10'h030f; // reload [7:0]
    localparam logic [9:0] OFF_FLAG_CLR = 10'h0310;  // timeout flag clear
    localparam logic [9:0] OFF_STATUS = 10'h0311;    // timeout status
    localparam logic [9:0] OFF_IRQ_STAT = 10'h0320;  // sticky events
    localparam logic [9:0] OFF_IRQ_MASK = 10'h0321;  // event mask

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TRIM_MSB = 6;       // coarse trim field [6:3]
    localparam int TRIM_LSB = 3;
    localparam int DIV_MSB = 2;        // divider select field [2:0]
    localparam int BIT_RC_EN = 6;      // rc oscillator enable
    localparam int BIT_XTAL_EN = 5;    // crystal oscillator enable
    localparam int BIT_CLKSEL = 4;     // 1 rc, 0 crystal
    localparam int BIT_RETAIN = 3;     // retention ram power in sleep
    localparam int BIT_ARM = 0;        // wake on timeout
    localparam int BIT_FLAG_CLR = 0;   // write 1 clears latched flag
    localparam int BIT_ST_FLAG = 1;    // latched timeout flag
    localparam int BIT_ST_EVENT = 0;   // instantaneous timeout
    localparam int BIT_IRQ_TMO = 0;    // timeout interrupt source

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_RLD = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [3:0] TRIM_NOMINAL = 4'b1101; // 0% frequency shift

    // ----------------------------------------------------------------
    // divider table: source edges per tick, minus one
    // ----------------------------------------------------------------
    function automatic logic [15:0] div_last(input logic [2:0] sel);
        case (sel)
            3'd0: div_last = 16'h0000; // divide by 1
            3'd1: div_last = 16'h0003; // divide by 4
            3'd2: div_last = 16'h0007; // divide by 8
            3'd3: div_last = 16'h000f; // divide by 16
            3'd4: div_last = 16'h007f; // divide by 128
            3'd5: div_last = 16'h03ff; // divide by 1024
            3'd6: div_last = 16'h1fff; // divide by 8192
            default: div_last = 16'hffff; // divide by 65536
        endcase
    endfunction

endpackage

/* rtl/wut_tick_if.sv */
// wake-up timer interface: prescaled tick from divider to countdown
`timescale 1ns/10ps
`default_nettype none
interface wut_tick_if;
    logic tick; // one-cycle enable at the prescaled rate
    modport prescaler (output tick);
    modport counter (input tick);
endinterface
`default_nettype wire

/* rtl/wut_prescaler.sv */
// wake-up timer prescaler: divides the 32 kHz edge pulses into ticks
`timescale 1ns/10ps
`default_nettype none
module wut_prescaler (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic src_pulse_i,     // one pulse per source period
    input wire logic [2:0] div_sel_i, // divider code
    input wire logic restart_i,       // config applied, restart division
    wut_tick_if.prescaler tk
);
    import wut_pkg::*;

    logic [15:0] div_cnt; // source edges seen in this tick period

    // ----------------------------------------------------------------
    // division counter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt <= RST_COUNT;
        end else if (restart_i) begin
            div_cnt <= RST_COUNT;
        end else if (src_pulse_i) begin
            // wrap at the selected divisor
            if (div_cnt >= div_last(div_sel_i)) begin
                div_cnt <= RST_COUNT;
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end

    // tick on the last source edge of each period
    assign tk.tick = src_pulse_i && !restart_i
                     && (div_cnt >= div_last(div_sel_i));

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_TICK_SPACING: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        tk.tick && div_sel_i != 3'd0 |-> !$past(tk.tick))
        else $error("prescaled tick repeated with divider above one");

endmodule // wut_prescaler
`default_nettype wire

/* rtl/wut_countdown.sv */
// wake-up timer countdown: 16-bit down counter with reload
`timescale 1ns/10ps
`default_nettype none
module wut_countdown (
    input wire logic mclk_i,
    input wire logic nrst_i,
    wut_tick_if.counter tk,
    input wire logic load_i,             // reload value just committed
    input wire logic [15:0] reload_i,    // committed reload value
    output logic [15:0] count_o,         // present count
    output logic timeout_o               // count reached zero this tick
);
    import wut_pkg::*;

    logic [15:0] next_count; // count after this tick

    // on zero reload and keep going, else step down
    always_comb begin
        next_count = (count_o == RST_COUNT) ? reload_i
                                            : count_o - 16'h0001;
    end

    // ----------------------------------------------------------------
    // counter register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_o <= RST_COUNT;
        end else if (load_i) begin
            count_o <= reload_i;
        end else if (tk.tick) begin
            count_o <= next_count;
        end
    end

    // event when a tick brings the count to zero
    assign timeout_o = tk.tick && !load_i && next_count == RST_COUNT;

    AST_STEP_DOWN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        tk.tick && !load_i && count_o != 16'h0000
        |=> count_o == $past(count_o) - 16'h0001)
        else $error("count did not step down on a tick");

    AST_RELOAD: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        tk.tick && !load_i && count_o == 16'h0000
        |=> count_o == $past(reload_i))
        else $error("count did not reload after timeout");

endmodule // wut_countdown
`default_nettype wire

/* test/wut_top_bench.sv */
// wake-up timer bench: register tasks and timeout scenarios
`timescale 1ns/10ps
`default_nettype none
module wut_top_bench;
    import wut_pkg::*;
    logic mclk_i, nrst_i, wr_i, rd_i, rc_clk, xt_clk, sleep;
    logic [9:0] addr;
    logic [7:0] wdat, rdat;
    logic rc_en, xt_en, keep, wake, irq;
    logic [3:0] trim;
    int n_mismatch, total_checks, cyc, n_wake;
    int div_n[6] = '{1, 4, 8, 16, 128, 1024};
    // ------------------------------------------------------------
    // device under test
    // ------------------------------------------------------------
    wut_top uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr),
        .wr_data_i(wdat), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rdat),
        .rc_osc_clk_i(rc_clk), .xtal_osc_clk_i(xt_clk),
        .rc_osc_enable_o(rc_en), .crystal_osc_enable_o(xt_en),
        .rc_osc_coarse_trim_o(trim), .sleep_state_i(sleep),
        .retention_ram_power_keep_o(keep), .wake_o(wake), .irq_o(irq));
    // 5 ns clock
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // wake pulse counter and hang guard
    always @(posedge mclk_i) begin
        if (wake === 1'b1) n_wake++;
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a; wdat <= d; wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // read strobe, data sampled in the following cycle only
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr <= a; rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdat, exp);
    endtask
    // rc or crystal oscillator edges, held well beyond the synchroniser
    task automatic pulse(input int n, input bit xt = 1'b0);
        repeat (n) begin
            @(posedge mclk_i);
            if (xt) xt_clk <= 1'b1;
            else rc_clk <= 1'b1;
            repeat (4) @(posedge mclk_i);
            {rc_clk, xt_clk} <= 2'b00;
            repeat (4) @(posedge mclk_i);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst_i, wr_i, rd_i, rc_clk, xt_clk, sleep} = 6'b0;
        addr = 10'h000; wdat = 8'h00;
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rd(OFF_CFG_UPPER, 8'h00);
        rd(10'h03ff, 8'h00);
        // oscillator enables, trim and retention follow the lower write
        wr(OFF_CFG_UPPER, 8'h68);
        wr(OFF_CFG_LOWER, 8'h79);
        @(posedge mclk_i);
        #1 chk({rc_en, xt_en, keep, 1'b0, trim}, 8'he0 | 8'h0d);
        // every measurable divider ratio, reload of one
        for (int c = 0; c < 6; c++) begin
            wr(OFF_CFG_UPPER, 8'h68 | 8'(c));
            wr(OFF_CFG_LOWER, 8'h51);
            wr(OFF_RLD_UPPER, 8'h00);
            wr(OFF_RLD_LOWER, 8'h01);
            wr(OFF_FLAG_CLR, 8'h01);
            pulse(div_n[c] - 1);
            rd(OFF_STATUS, 8'h00);
            pulse(1);
            rd(OFF_STATUS, 8'h03);
        end
        #1 chk({rc_en, xt_en, keep, 5'h00}, 8'h80);
        // staged upper byte must not reach the counter
        wr(OFF_CFG_UPPER, 8'h68);
        wr(OFF_CFG_LOWER, 8'h51);
        wr(OFF_RLD_UPPER, 8'h00);
        wr(OFF_RLD_LOWER, 8'h02);
        wr(OFF_FLAG_CLR, 8'h01);
        wr(OFF_RLD_UPPER, 8'h05);
        sleep <= 1'b1;
        n_wake = 0;
        pulse(2);
        rd(OFF_STATUS, 8'h03);
        chk(8'(n_wake), 8'h01);
        pulse(1);
        rd(OFF_STATUS, 8'h02);
        // disarmed: timeout without wake
        wr(OFF_FLAG_CLR, 8'h01);
        wr(OFF_CFG_UPPER, 8'h68);
        wr(OFF_CFG_LOWER, 8'h50);
        pulse(2);
        rd(OFF_STATUS, 8'h03);
        chk(8'(n_wake), 8'h01);
        // crystal selected: rc edges ignored, crystal edges counted
        wr(OFF_FLAG_CLR, 8'h01);
        wr(OFF_CFG_UPPER, 8'h68);
        wr(OFF_CFG_LOWER, 8'h60);
        pulse(1);
        rd(OFF_STATUS, 8'h01);
        pulse(3, 1'b1);
        rd(OFF_STATUS, 8'h03);
        // rc selected but disabled: its edges do not count
        wr(OFF_FLAG_CLR, 8'h01);
        wr(OFF_CFG_UPPER, 8'h68);
        wr(OFF_CFG_LOWER, 8'h30);
        pulse(1);
        rd(OFF_STATUS, 8'h01);
        // interrupt mask, sticky status cleared by read
        wr(OFF_IRQ_MASK, 8'h01);
        rd(OFF_IRQ_MASK, 8'h01);
        #1 chk({7'h00, irq}, 8'h01);
        rd(OFF_IRQ_STAT, 8'h01);
        repeat (3) @(posedge mclk_i);
        #1 chk({7'h00, irq}, 8'h00);
        rd(OFF_IRQ_STAT, 8'h00);
        report_and_stop();
    end
endmodule // wut_top_bench
`default_nettype wire
